//--- ccs_host_model.sv
// Host side model driving the enable and rate select inputs
`timescale 1ns/1ns
module ccs_host_model (
    // Clock
    input wire logic aclk,
    // Host controls
    output logic charge_en_n,
    output logic rate_select
);
    // A cautious host keeps charging off until asked
    initial
    begin
        charge_en_n = 1'b1;
        rate_select = 1'b0;
    end
    // Enable is active low; the delay lets the host answer slowly
    task automatic set_en(input logic on, input int dly);
        repeat (dly) @(posedge aclk);
        charge_en_n <= ~on;
    endtask
    // High asks for the fast rate, low for the precharge rate
    task automatic set_rate(input logic fast);
        rate_select <= fast;
    endtask
endmodule // ccs_host_model

//--- ccs_pkg.sv
// Package of constants and types for the charge cycle supervisor
package ccs_pkg;
    // Register byte offsets
    localparam logic [7:0] CCS_CTRL_OFS = 8'h00;
    localparam logic [7:0] CCS_STAT_OFS = 8'h04;
    localparam logic [7:0] CCS_PRE_OFS = 8'h08;
    localparam logic [7:0] CCS_FAST_OFS = 8'h0c;
    // Control field positions and reset value
    localparam int CCS_CTRL_ALT = 0;
    localparam int CCS_CTRL_HOST = 1;
    localparam logic [31:0] CCS_CTRL_RST = 32'h0000_0000;
    // Timer reset values, in seconds ticks
    localparam logic [31:0] CCS_PRE_RST = 32'h0000_0708;
    localparam logic [31:0] CCS_FAST_RST = 32'h0000_4650;
    // Clock and blink timing
    localparam int CCS_CLK_HZ = 125000000;
    localparam int CCS_BLINK_MHZ = 500;
    localparam int CCS_HALF_CYC = (CCS_CLK_HZ / 1000 * 1000) / (2 * CCS_BLINK_MHZ) * 1000;
    // AXI responses
    localparam logic [1:0] CCS_RESP_OK = 2'h0;
    localparam logic [1:0] CCS_RESP_ERR = 2'h2;
    // Charge states
    typedef enum logic [8:0] {
        CCS_SLEEP = 9'h001,
        CCS_IDLE = 9'h002,
        CCS_PRE = 9'h004,
        CCS_FAST = 9'h008,
        CCS_VREG = 9'h010,
        CCS_DONE = 9'h020,
        CCS_FAULT = 9'h040,
        CCS_OVP = 9'h080,
        CCS_DETECT = 9'h100
    } ccs_state_e;
endpackage

//--- ccs_props.sv
// Checker of port relations for the charge cycle supervisor
`timescale 1ns/1ns
module ccs_props (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Watched inputs
    input wire logic supply_ok,
    input wire logic above_wake,
    input wire logic below_term_current,
    input wire logic over_voltage,
    input wire logic temp_ok,
    input wire logic charge_en_n,
    input wire logic s_axi_arvalid,
    // Watched outputs
    input wire logic switch_en,
    input wire logic probe_current,
    input wire logic indicator_a,
    input wire logic indicator_b,
    input wire logic supply_present_out,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Outputs come from the next state, so every effect lands one edge after its cause
    a_sleep_off: assert property (
        !supply_ok |=> !supply_present_out && !switch_en) else $error("sleep left power on");
    a_sleep_dark: assert property (
        !supply_ok |=> !indicator_a && !indicator_b) else $error("indicator lit in sleep");
    a_wake_cause: assert property (
        $rose(supply_present_out) |-> $past(above_wake)) else $error("supply flag without wake");
    a_ovp_off: assert property (
        over_voltage |=> !switch_en && !indicator_a && !indicator_b) else $error("overvoltage");
    a_enable_stop: assert property (
        charge_en_n |=> !switch_en) else $error("switching while disabled");
    a_suspend_stop: assert property (
        !temp_ok |=> !switch_en) else $error("switching in suspend");
    a_led_excl: assert property (
        !(indicator_a && indicator_b)) else $error("both indicators lit");
    a_done_cause: assert property (
        $rose(indicator_b) |-> $past(below_term_current)) else $error("complete without term");
    a_read_lat: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
    // Main scenarios reached
    c_done: cover property ($rose(indicator_b));
    c_probe: cover property ($rose(probe_current));
    c_blink: cover property ($fell(indicator_a) && !indicator_b);
endmodule // ccs_props

bind ccs_top ccs_props u_ccs_props (.aclk, .aresetn, .supply_ok, .above_wake,
    .below_term_current, .over_voltage, .temp_ok, .charge_en_n, .s_axi_arvalid, .switch_en,
    .probe_current, .indicator_a, .indicator_b, .supply_present_out, .s_axi_arready,
    .s_axi_rvalid);

//--- ccs_top.sv
// Charge cycle supervisor sequencer with AXI4-Lite register slave
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
module ccs_top
    import ccs_pkg::*;
#(
    parameter int HALF_CYC = CCS_HALF_CYC,
    parameter int SEC_CYC = CCS_CLK_HZ
)(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Analog comparator results
    input wire logic supply_ok,
    input wire logic above_wake,
    input wire logic below_recharge,
    input wire logic below_precharge_exit,
    input wire logic at_regulation,
    input wire logic below_term_current,
    input wire logic over_voltage,
    input wire logic temp_ok,
    input wire logic batt_short,
    // Timer pin state from comparators
    input wire logic timer_pin_low,
    input wire logic timer_pin_high,
    // Host controls
    input wire logic charge_en_n,
    input wire logic rate_select,
    // Power stage controls
    output logic switch_en,
    output logic fast_rate,
    output logic probe_current,
    // Open-drain indicators, enable high means pulled low
    output logic indicator_a,
    output logic indicator_b,
    output logic supply_present_out,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    ccs_state_e state_r, state_nxt;
    logic [31:0] ctrl_r, pre_lim_r, fast_lim_r;
    logic [31:0] sec_cnt_r, tmr_r;
    logic [31:0] blink_cnt_r;
    logic blink_r, en_n_d_r, pin_low_d_r, fault_hi_r;
    logic [7:0] aw_addr_r;
    logic aw_have_r, w_have_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;

    // Merge write data under the byte strobes
    function automatic logic [31:0] ccs_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] stb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
            if (stb[i])
                res[i*8 +: 8] = nw[i*8 +: 8];
        return res;
    endfunction

    // Mode and event decode
    wire host_mode = ctrl_r[CCS_CTRL_HOST];
    wire alt_enc = ctrl_r[CCS_CTRL_ALT];
    wire en_fall = en_n_d_r & ~charge_en_n;
    wire en_rise = ~en_n_d_r & charge_en_n;
    wire en_toggle = en_fall | en_rise;
    wire pin_rise = pin_low_d_r & ~timer_pin_low;
    wire term_on = ~timer_pin_low & ~host_mode;
    wire timer_on = ~timer_pin_low & ~timer_pin_high & ~host_mode;
    wire suspend = ~temp_ok;
    wire in_charge = (state_r == CCS_PRE) | (state_r == CCS_FAST) | (state_r == CCS_VREG);
    wire sec_tick = (sec_cnt_r == 32'(SEC_CYC - 1));
    wire clr_tmr = en_fall | pin_rise | (state_nxt != state_r);
    wire pre_exp = timer_on & (tmr_r >= pre_lim_r);
    wire fast_exp = timer_on & (tmr_r >= fast_lim_r);
    wire restart = en_toggle | pin_rise;

    // Next charge state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            CCS_SLEEP:
                if (above_wake)
                    state_nxt = CCS_IDLE;
            CCS_IDLE:
                if (!charge_en_n && temp_ok)
                    state_nxt = (below_precharge_exit && !host_mode) ? CCS_PRE : CCS_FAST;
            CCS_PRE:
                if (!below_precharge_exit)
                    state_nxt = CCS_FAST;
                else if (pre_exp && !suspend)
                    state_nxt = CCS_FAULT;
            CCS_FAST:
                if (at_regulation)
                    state_nxt = CCS_VREG;
                else if (fast_exp && !suspend)
                    state_nxt = CCS_FAULT;
            CCS_VREG:
                if (term_on && below_term_current)
                    state_nxt = CCS_DONE;
                else if (fast_exp && !suspend)
                    state_nxt = CCS_FAULT;
            CCS_DONE:
                if (below_recharge)
                    state_nxt = CCS_DETECT;
            CCS_FAULT:
                if (fault_hi_r && below_recharge)
                    state_nxt = CCS_DETECT;
            CCS_OVP:
                if (below_recharge)
                    state_nxt = CCS_IDLE;
            CCS_DETECT:
                if (batt_short || !below_recharge)
                    state_nxt = CCS_IDLE;
            default:
                state_nxt = CCS_SLEEP;
        endcase
        // Global overrides, ordered by priority
        if (restart && state_r != CCS_SLEEP && state_r != CCS_OVP)
            state_nxt = CCS_IDLE;
        if (charge_en_n && in_charge)
            state_nxt = CCS_IDLE;
        if (over_voltage && state_r != CCS_SLEEP)
            state_nxt = CCS_OVP;
        if (!supply_ok)
            state_nxt = CCS_SLEEP;
    end

    // Sequencer state and edge history
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= CCS_SLEEP;
            en_n_d_r <= 1'b1;
            pin_low_d_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            en_n_d_r <= charge_en_n;
            pin_low_d_r <= timer_pin_low;
        end
    end

    // Fault sub-condition: battery has been above recharge since the timeout
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            fault_hi_r <= 1'b0;
        else if (state_r != CCS_FAULT)
            fault_hi_r <= 1'b0;
        else if (!below_recharge)
            fault_hi_r <= 1'b1;
    end

    // Safety timer; held during suspend rather than reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn || clr_tmr)
        begin
            sec_cnt_r <= '0;
            tmr_r <= '0;
        end
        else if (in_charge && timer_on && !suspend)
        begin
            sec_cnt_r <= sec_tick ? '0 : sec_cnt_r + 32'h1;
            if (sec_tick)
                tmr_r <= tmr_r + 32'h1;
        end
    end

    // Blink square wave, free running so phase is independent of state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            blink_cnt_r <= '0;
            blink_r <= 1'b0;
        end
        else if (blink_cnt_r == 32'(HALF_CYC - 1))
        begin
            blink_cnt_r <= '0;
            blink_r <= ~blink_r;
        end
        else
            blink_cnt_r <= blink_cnt_r + 32'h1;
    end

    // Output decode
    wire chg_nxt = (state_nxt == CCS_PRE) | (state_nxt == CCS_FAST) | (state_nxt == CCS_VREG);
    wire blink_state = (state_nxt == CCS_FAULT) | (chg_nxt & suspend) | (state_nxt == CCS_DETECT &
                       batt_short);
    wire ind_a_nxt = alt_enc & blink_state ? blink_r : (chg_nxt & ~suspend);
    wire ind_b_nxt = (state_nxt == CCS_DONE);
    wire sw_nxt = chg_nxt & ~suspend & ~charge_en_n;
    wire fast_nxt = host_mode ? rate_select : (state_nxt != CCS_PRE);
    wire probe_nxt = (state_nxt == CCS_FAULT) & ~fault_hi_r & below_recharge;

    // Registered outputs
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            switch_en <= 1'b0;
            fast_rate <= 1'b0;
            probe_current <= 1'b0;
            indicator_a <= 1'b0;
            indicator_b <= 1'b0;
            supply_present_out <= 1'b0;
        end
        else
        begin
            switch_en <= sw_nxt;
            fast_rate <= fast_nxt;
            probe_current <= probe_nxt;
            indicator_a <= ind_a_nxt;
            indicator_b <= ind_b_nxt;
            supply_present_out <= (state_nxt != CCS_SLEEP);
        end
    end

    // AXI decode: address and data may arrive in either order
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;
    wire wr_ctrl = wr_go & (aw_addr_r == CCS_CTRL_OFS);
    wire wr_pre = wr_go & (aw_addr_r == CCS_PRE_OFS);
    wire wr_fast = wr_go & (aw_addr_r == CCS_FAST_OFS);
    wire wr_ok = wr_ctrl | wr_pre | wr_fast;
    wire rd_take = s_axi_arvalid & s_axi_arready;
    wire rd_ok = (s_axi_araddr == CCS_CTRL_OFS) | (s_axi_araddr == CCS_STAT_OFS) |
                 (s_axi_araddr == CCS_PRE_OFS) | (s_axi_araddr == CCS_FAST_OFS);
    wire [31:0] stat_word = {tmr_r[15:0], 7'h0, state_r};
    wire [31:0] rd_mux = (s_axi_araddr == CCS_CTRL_OFS) ? ctrl_r :
                         (s_axi_araddr == CCS_STAT_OFS) ? stat_word :
                         (s_axi_araddr == CCS_PRE_OFS) ? pre_lim_r :
                         (s_axi_araddr == CCS_FAST_OFS) ? fast_lim_r : 32'h0;

    // Write channel capture and response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= '0;
            w_strb_r <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= CCS_RESP_OK;
        end
        else
        begin
            s_axi_awready <= ~aw_have_r & ~aw_take & ~s_axi_bvalid;
            s_axi_wready <= ~w_have_r & ~w_take & ~s_axi_bvalid;
            if (aw_take)
            begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (w_take)
            begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? CCS_RESP_OK : CCS_RESP_ERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Software registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r <= CCS_CTRL_RST;
            pre_lim_r <= CCS_PRE_RST;
            fast_lim_r <= CCS_FAST_RST;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_r <= ccs_merge(ctrl_r, w_data_r, w_strb_r) & 32'h3;
            if (wr_pre)
                pre_lim_r <= ccs_merge(pre_lim_r, w_data_r, w_strb_r);
            if (wr_fast)
                fast_lim_r <= ccs_merge(fast_lim_r, w_data_r, w_strb_r);
        end
    end

    // Read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= CCS_RESP_OK;
        end
        else
        begin
            s_axi_arready <= ~s_axi_rvalid & ~rd_take & ~s_axi_arready;
            if (rd_take)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_ok ? CCS_RESP_OK : CCS_RESP_ERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule // ccs_top

//--- charge_cycle_supervisor_tb_top.sv
// Self-checking bench of the charge cycle supervisor
`timescale 1ns/1ns
module charge_cycle_supervisor_tb_top;
    import ccs_pkg::*;
    logic aclk, aresetn, supply_ok, above_wake, below_recharge, below_precharge_exit;
    logic at_regulation, below_term_current, over_voltage, temp_ok, timer_pin_low;
    logic batt_short, timer_pin_high;
    logic charge_en_n, rate_select, switch_en, fast_rate, probe_current;
    logic indicator_a, indicator_b, supply_present_out, prev;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [5:0] obs;
    int n_errors, checks, cycles, toggles;
    // Short blink and second counts keep the run brief
    ccs_top #(.HALF_CYC(4), .SEC_CYC(10)) u_ccs_top (.aclk, .aresetn, .supply_ok, .above_wake,
        .below_recharge, .below_precharge_exit, .at_regulation, .below_term_current,
        .over_voltage, .temp_ok, .batt_short, .timer_pin_low, .timer_pin_high,
        .charge_en_n, .rate_select, .switch_en, .fast_rate, .probe_current, .indicator_a,
        .indicator_b, .supply_present_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    ccs_host_model u_ccs_host_model (.aclk, .charge_en_n, .rate_select);
    // Port view: supply flag, switching, fast rate, probe, indicator a, indicator b
    assign obs = {supply_present_out, switch_en, fast_rate, probe_current, indicator_a, indicator_b};
    // Clock
    initial
    begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // Hang guard
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_errors++;
            $display("ERROR %0t: timeout", $time);
            test_done;
        end
    end
    task automatic test_done;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Compare masked port view
    task automatic see(input logic [5:0] e, input logic [5:0] m);
        chk({26'h0, obs & m}, {26'h0, e});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // Write: both channels offered, each dropped when taken, then wait for the response
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic da, dw;
        da = 1'b0;
        dw = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(da && dw))
        begin
            @(posedge aclk);
            // Each channel is released only at the edge that took it
            if (s_axi_awvalid && s_axi_awready)
            begin
                da = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                dw = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        @(posedge aclk);
    endtask
    // Read with a mask on the returned word
    task automatic axr(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata & m, e);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        @(posedge aclk);
    endtask
    // Main sequence
    initial
    begin
        {n_errors, checks} = '0;
        {aresetn, supply_ok, above_wake, below_recharge, below_precharge_exit} = '0;
        {at_regulation, below_term_current, over_voltage, timer_pin_low} = '0;
        {batt_short, timer_pin_high} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        temp_ok = 1'b1;
        cyc(8);
        aresetn <= 1'b1;
        cyc(1);
        axr(CCS_CTRL_OFS, '1, CCS_CTRL_RST, CCS_RESP_OK);
        axr(CCS_STAT_OFS, 32'h1ff, 32'h1, CCS_RESP_OK);
        axr(CCS_PRE_OFS, '1, CCS_PRE_RST, CCS_RESP_OK);
        axr(CCS_FAST_OFS, '1, CCS_FAST_RST, CCS_RESP_OK);
        axr(8'h10, '1, 32'h0, CCS_RESP_ERR);
        axw(8'h14, 32'h1, CCS_RESP_ERR);
        {supply_ok, above_wake, below_recharge, below_precharge_exit} <= 4'hf;
        u_ccs_host_model.set_en(1'b1, 3);
        cyc(8);
        see(6'b110010, 6'b111111);
        below_precharge_exit <= 1'b0;
        cyc(4);
        see(6'b111010, 6'b111111);
        temp_ok <= 1'b0;
        cyc(3);
        see(6'b100000, 6'b110011);
        temp_ok <= 1'b1;
        // A battery at regulation sits above the recharge level, else done restarts at once
        {at_regulation, below_term_current, below_recharge} <= 3'b110;
        cyc(8);
        see(6'b100001, 6'b110011);
        over_voltage <= 1'b1;
        cyc(3);
        see(6'b100000, 6'b110011);
        // Battery falls back to the recharge level, which clears the overvoltage fault
        {over_voltage, at_regulation, below_term_current, below_precharge_exit, below_recharge} <= 5'h3;
        axw(CCS_PRE_OFS, 32'h2, CCS_RESP_OK);
        u_ccs_host_model.set_en(1'b0, 0);
        cyc(3);
        see(6'b100000, 6'b110000);
        u_ccs_host_model.set_en(1'b1, 0);
        cyc(8);
        see(6'b110010, 6'b111111);
        cyc(30);
        see(6'b100100, 6'b110111);
        axw(CCS_CTRL_OFS, 32'h1, CCS_RESP_OK);
        cyc(4);
        toggles = 0;
        prev = indicator_a;
        repeat (16)
        begin
            @(posedge aclk);
            if (indicator_a !== prev) toggles++;
            prev = indicator_a;
        end
        chk(toggles, 4);
        // Back to standard encoding so the next fault shows a dark indicator
        axw(CCS_CTRL_OFS, 32'h0, CCS_RESP_OK);
        timer_pin_low <= 1'b1;
        u_ccs_host_model.set_en(1'b0, 0);
        cyc(2);
        u_ccs_host_model.set_en(1'b1, 0);
        cyc(40);
        see(6'b110010, 6'b110111);
        timer_pin_low <= 1'b0;
        cyc(8);
        see(6'b110010, 6'b110111);
        cyc(25);
        see(6'b100100, 6'b110111);
        // Pin tied high: the short precharge limit must not fault any more
        timer_pin_high <= 1'b1;
        u_ccs_host_model.set_en(1'b0, 0);
        cyc(2);
        u_ccs_host_model.set_en(1'b1, 0);
        cyc(30);
        see(6'b110010, 6'b110111);
        timer_pin_high <= 1'b0;
        // A short fast limit shows that the host variant runs no timer
        axw(CCS_FAST_OFS, 32'h2, CCS_RESP_OK);
        axw(CCS_CTRL_OFS, 32'h2, CCS_RESP_OK);
        u_ccs_host_model.set_en(1'b0, 0);
        cyc(2);
        u_ccs_host_model.set_en(1'b1, 0);
        u_ccs_host_model.set_rate(1'b1);
        cyc(8);
        see(6'b011000, 6'b011000);
        u_ccs_host_model.set_rate(1'b0);
        cyc(30);
        see(6'b010000, 6'b011100);
        supply_ok <= 1'b0;
        cyc(3);
        see(6'b000000, 6'b110011);
        test_done;
    end
endmodule // charge_cycle_supervisor_tb_top
